// ===== design/hct_pkg.sv
// Overview of operation
// - In modes 1 to 3 the first clock rises at bits 5:0 and falls at bits 13:8 of its edge register; in 3-phase mode that register places phase 3.
// - The second edge register drives the second clock in mode 2, the fifth clock in mode 3 and phase 2 in 3-phase mode.
// - The last-stage clock takes its rising edge from bits 5:0 and its falling edge from bits 13:8 of its own register, falling edge resetting to 0x20.
// - In 3-phase mode phase 1 takes both edges from a dedicated register whose falling edge resets to 0x20.
// - The reset-gate clock rises at bits 5:0 and falls at bits 13:8 of its register, falling edge resetting to 0x10.
// - Blanking-control bit 0 retimes the first clock's blanking by one stage; clear together with bit 20 means no retime.
// - Bits 1, 2 and 3 give the same retime for the second clock, the last-stage clock and the 3-phase clocks.
// - A nonzero 4-bit width at bits 7:4 widens the clocks during blanking; zero disables it.
// - Blanking reaches the last-stage clock only while bit 9 is one.
// - Bits 20 to 23 each add one more retime stage to the blanking of the first, second, last-stage or 3-phase clocks.
// - Five 3-bit drive codes, each resetting to 1, enable the output drivers; code zero turns a driver off.
package hct_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 28;
  localparam int LOC_W = 6;
  localparam int MODE_W = 5;
  localparam int DRV_W = 3;
  localparam int NUM_EDGE = 5;
  localparam int NUM_DRV = 5;
  // Register offsets
  localparam logic [7:0] OFS_SCHEME = 8'h24;
  localparam logic [7:0] OFS_FIRST = 8'h30;
  localparam logic [7:0] OFS_SECOND = 8'h31;
  localparam logic [7:0] OFS_LAST = 8'h32;
  localparam logic [7:0] OFS_PHASE1 = 8'h33;
  localparam logic [7:0] OFS_RGATE = 8'h34;
  localparam logic [7:0] OFS_BLANK = 8'h35;
  localparam logic [7:0] OFS_DRIVE = 8'h36;
  localparam logic [7:0] OFS_STATUS = 8'h3B;
  // Field positions
  localparam int RISE_LSB = 0;
  localparam int FALL_LSB = 8;
  localparam int TEST_BIT = 16;
  localparam int BLK_RESYNC_LSB = 0;
  localparam int BLK_WIDTH_LSB = 4;
  localparam int BLK_LAST_EN = 9;
  localparam int BLK_EXTRA_LSB = 20;
  localparam int DRV_STRIDE = 4;
  localparam int DRV_LAST_LSB = 16;
  // Group index inside the resync and extra fields
  localparam int GRP_FIRST = 0;
  localparam int GRP_SECOND = 1;
  localparam int GRP_LAST = 2;
  localparam int GRP_3PH = 3;
  // Reset values
  localparam logic [27:0] RST_EDGE = 28'h0012000;
  localparam logic [27:0] RST_RGATE = 28'h0011000;
  localparam logic [27:0] RST_BLANK = 28'h0000000;
  localparam logic [27:0] RST_DRIVE = 28'h0011111;
  localparam logic [4:0] RST_SCHEME = 5'h01;
  // Scheme codes
  localparam logic [4:0] CODE_MODE1 = 5'h01;
  localparam logic [4:0] CODE_MODE2 = 5'h02;
  localparam logic [4:0] CODE_MODE3 = 5'h04;
  localparam logic [4:0] CODE_3PH = 5'h10;
  // Last fine position in a pixel period
  localparam logic [5:0] LAST_POS = 6'h3F;

  typedef enum logic [2:0] {SCH_MODE1, SCH_MODE2, SCH_MODE3, SCH_3PH, SCH_BAD} hct_scheme_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } hct_reg_req_s;

  function automatic logic [LOC_W-1:0] riseLoc(input logic [DATA_W-1:0] r);
    riseLoc = r[RISE_LSB +: LOC_W];
  endfunction : riseLoc

  function automatic logic [LOC_W-1:0] fallLoc(input logic [DATA_W-1:0] r);
    fallLoc = r[FALL_LSB +: LOC_W];
  endfunction : fallLoc

  function automatic hct_scheme_e decodeScheme(input logic [MODE_W-1:0] c);
    case (c)
      CODE_MODE1: decodeScheme = SCH_MODE1;
      CODE_MODE2: decodeScheme = SCH_MODE2;
      CODE_MODE3: decodeScheme = SCH_MODE3;
      CODE_3PH: decodeScheme = SCH_3PH;
      default: decodeScheme = SCH_BAD;
    endcase
  endfunction : decodeScheme
endpackage : hct_pkg

// ===== design/hct_edge_gen.sv
`timescale 1ns/1ns
// One clock level driven by a rise and a fall location
module hct_edge_gen #(
  parameter int LOC_W = 6
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [LOC_W-1:0] pos,
  input wire logic [LOC_W-1:0] rise,
  input wire logic [LOC_W-1:0] fall,
  output logic lvl
);
  // Rise wins when both locations match, so the clock never sticks low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lvl <= 1'b0;
    end else if (pos == rise) begin
      lvl <= 1'b1;
    end else if (pos == fall) begin
      lvl <= 1'b0;
    end
  end

  property p_rise;
    @(posedge core_clk) disable iff (!nrst)
      (pos == rise) |=> lvl;
  endproperty
  a_rise: assert property (p_rise) else $error("level not high after rise location");

  property p_fall;
    @(posedge core_clk) disable iff (!nrst)
      (pos == fall && pos != rise) |=> !lvl ##1 (lvl == $past(lvl) || $past(pos) == rise);
  endproperty
  a_fall: assert property (p_fall) else $error("level not low after fall location");
endmodule : hct_edge_gen

// ===== design/hct_timing_core.sv
`timescale 1ns/1ns
// Horizontal clock timing core: edge placement, blanking and driver enables
module hct_timing_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire hct_pkg::hct_reg_req_s regReq,
  output logic [hct_pkg::DATA_W-1:0] regRdata,
  input wire logic hblankIn,
  output logic [7:0] transferClk,
  output logic lastStageClk,
  output logic resetGateClk,
  output logic [hct_pkg::NUM_DRV-1:0] driveEn
);
  import hct_pkg::*;

  logic [DATA_W-1:0] firstEdges_q;
  logic [DATA_W-1:0] secondEdges_q;
  logic [DATA_W-1:0] lastEdges_q;
  logic [DATA_W-1:0] phaseOneEdges_q;
  logic [DATA_W-1:0] resetGateEdges_q;
  logic [DATA_W-1:0] blankCtl_q;
  logic [DATA_W-1:0] driveCtl_q;
  logic [MODE_W-1:0] scheme_q;
  logic [LOC_W-1:0] pos_q;
  logic blankDly1_q;
  logic blankDly2_q;
  logic [3:0] widePix_q;
  logic wideClk_q;
  logic [NUM_EDGE-1:0] lvl;
  logic [DATA_W-1:0] edgeRegs [NUM_EDGE];
  hct_scheme_e scheme;
  logic blankFirst;
  logic blankSecond;
  logic blankLast;
  logic blank3ph;
  logic [3:0] wideWidth;
  logic wideOn;
  logic [7:0] transferClk_d;
  logic lastStageClk_d;
  logic [DATA_W-1:0] rdata_d;

  // Pick a blanking tap from how many retime stages are enabled
  function automatic logic blankTap(input logic raw, input logic d1, input logic d2,
                                    input logic resync, input logic extra);
    case ({resync, extra})
      2'b00: blankTap = raw;
      2'b11: blankTap = d2;
      default: blankTap = d1;
    endcase
  endfunction : blankTap

  // During blanking a clock is parked low or follows the wide clock
  function automatic logic blanked(input logic clk, input logic blk, input logic on,
                                   input logic wide);
    blanked = blk ? (on & wide) : clk;
  endfunction : blanked

  // Register writes; reserved bits are stored as written so readback is honest, except in the scheme register, which keeps bits 4:0 only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      firstEdges_q <= RST_EDGE;
      secondEdges_q <= RST_EDGE;
      lastEdges_q <= RST_EDGE;
      phaseOneEdges_q <= RST_EDGE;
      resetGateEdges_q <= RST_RGATE;
      blankCtl_q <= RST_BLANK;
      driveCtl_q <= RST_DRIVE;
      scheme_q <= RST_SCHEME;
    end else if (regReq.wr) begin
      case (regReq.addr)
        OFS_FIRST: firstEdges_q <= regReq.wdata;
        OFS_SECOND: secondEdges_q <= regReq.wdata;
        OFS_LAST: lastEdges_q <= regReq.wdata;
        OFS_PHASE1: phaseOneEdges_q <= regReq.wdata;
        OFS_RGATE: resetGateEdges_q <= regReq.wdata;
        OFS_BLANK: blankCtl_q <= regReq.wdata;
        OFS_DRIVE: driveCtl_q <= regReq.wdata;
        OFS_SCHEME: scheme_q <= regReq.wdata[MODE_W-1:0];
        default: ;
      endcase
    end
  end

  // Readback; unmapped offsets read zero
  always_comb begin
    rdata_d = '0;
    case (regReq.addr)
      OFS_FIRST: rdata_d = firstEdges_q;
      OFS_SECOND: rdata_d = secondEdges_q;
      OFS_LAST: rdata_d = lastEdges_q;
      OFS_PHASE1: rdata_d = phaseOneEdges_q;
      OFS_RGATE: rdata_d = resetGateEdges_q;
      OFS_BLANK: rdata_d = blankCtl_q;
      OFS_DRIVE: rdata_d = driveCtl_q;
      OFS_SCHEME: rdata_d = {{(DATA_W-MODE_W){1'b0}}, scheme_q};
      OFS_STATUS: rdata_d = {18'h00000, wideClk_q, blankFirst,
                             (scheme == SCH_BAD), 1'b0, pos_q};
      default: rdata_d = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= '0;
    end else if (regReq.rd) begin
      regRdata <= rdata_d;
    end else begin
      regRdata <= '0;
    end
  end

  // Fine position counter; one pixel period is 64 core cycles
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pos_q <= '0;
    end else begin
      pos_q <= pos_q + 6'h01;
    end
  end

  // Shared retime chain; each stage is one core cycle, the finest step this clock has
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      blankDly1_q <= 1'b0;
      blankDly2_q <= 1'b0;
    end else begin
      blankDly1_q <= hblankIn;
      blankDly2_q <= blankDly1_q;
    end
  end

  // Per-group blanking taps
  always_comb begin
    blankFirst = blankTap(hblankIn, blankDly1_q, blankDly2_q,
                          blankCtl_q[BLK_RESYNC_LSB + GRP_FIRST],
                          blankCtl_q[BLK_EXTRA_LSB + GRP_FIRST]);
    blankSecond = blankTap(hblankIn, blankDly1_q, blankDly2_q,
                           blankCtl_q[BLK_RESYNC_LSB + GRP_SECOND],
                           blankCtl_q[BLK_EXTRA_LSB + GRP_SECOND]);
    blankLast = blankCtl_q[BLK_LAST_EN] &
                blankTap(hblankIn, blankDly1_q, blankDly2_q,
                         blankCtl_q[BLK_RESYNC_LSB + GRP_LAST],
                         blankCtl_q[BLK_EXTRA_LSB + GRP_LAST]);
    blank3ph = blankTap(hblankIn, blankDly1_q, blankDly2_q,
                        blankCtl_q[BLK_RESYNC_LSB + GRP_3PH],
                        blankCtl_q[BLK_EXTRA_LSB + GRP_3PH]);
  end

  assign wideWidth = blankCtl_q[BLK_WIDTH_LSB +: 4];
  assign wideOn = (wideWidth != 4'h0);

  // Wide clock toggles every wideWidth pixel periods while blanking lasts
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      widePix_q <= '0;
      wideClk_q <= 1'b0;
    end else if (!hblankIn || !wideOn) begin
      widePix_q <= '0;
      wideClk_q <= 1'b0;
    end else if (pos_q == LAST_POS) begin
      if (widePix_q == wideWidth - 4'h1) begin
        widePix_q <= '0;
        wideClk_q <= ~wideClk_q;
      end else begin
        widePix_q <= widePix_q + 4'h1;
      end
    end
  end

  assign edgeRegs[0] = firstEdges_q;
  assign edgeRegs[1] = secondEdges_q;
  assign edgeRegs[2] = lastEdges_q;
  assign edgeRegs[3] = phaseOneEdges_q;
  assign edgeRegs[4] = resetGateEdges_q;

  // One edge generator per programmable clock
  for (genvar g = 0; g < NUM_EDGE; g++) begin : gEdge
    hct_edge_gen #(.LOC_W(LOC_W)) uEdge (
      .core_clk(core_clk),
      .nrst(nrst),
      .pos(pos_q),
      .rise(riseLoc(edgeRegs[g])),
      .fall(fallLoc(edgeRegs[g])),
      .lvl(lvl[g])
    );
  end

  assign scheme = decodeScheme(scheme_q);

  // Route edge levels to pins by scheme; an invalid code parks every transfer clock low, while the last-stage and reset-gate clocks keep running
  always_comb begin
    logic ea;
    logic eb;
    logic e1;
    logic e2;
    logic e3;
    ea = blanked(lvl[0], blankFirst, wideOn, wideClk_q);
    eb = blanked(lvl[1], blankSecond, wideOn, wideClk_q);
    e1 = blanked(lvl[3], blank3ph, wideOn, wideClk_q);
    e2 = blanked(lvl[1], blank3ph, wideOn, wideClk_q);
    e3 = blanked(lvl[0], blank3ph, wideOn, wideClk_q);
    transferClk_d = 8'h00;
    case (scheme)
      SCH_MODE1: transferClk_d = {~ea, ea, ~ea, ea, ~ea, ea, ~ea, ea};
      SCH_MODE2: transferClk_d = {eb, ea, eb, ea, eb, ea, eb, ea};
      SCH_MODE3: transferClk_d = {~eb, eb, ~eb, eb, ~ea, ea, ~ea, ea};
      SCH_3PH: transferClk_d = {e3, e3, e2, e2, 2'b00, e1, e1};
      default: transferClk_d = 8'h00;
    endcase
    lastStageClk_d = blanked(lvl[2], blankLast, wideOn, wideClk_q);
  end

  // Pin outputs come straight from flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      transferClk <= 8'h00;
      lastStageClk <= 1'b0;
      resetGateClk <= 1'b0;
    end else begin
      transferClk <= transferClk_d;
      lastStageClk <= lastStageClk_d;
      resetGateClk <= lvl[4];
    end
  end

  // Driver enables: code zero means the driver is off
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      driveEn <= '0;
    end else begin
      for (int i = 0; i < NUM_DRV - 1; i++) begin
        driveEn[i] <= (driveCtl_q[i*DRV_STRIDE +: DRV_W] != 3'h0);
      end
      driveEn[NUM_DRV-1] <= (driveCtl_q[DRV_LAST_LSB +: DRV_W] != 3'h0);
    end
  end

  property p_pos_wrap;
    @(posedge core_clk) disable iff (!nrst)
      (pos_q == LAST_POS) |=> (pos_q == 6'h00) ##63 (pos_q == LAST_POS);
  endproperty
  a_pos_wrap: assert property (p_pos_wrap) else $error("position count not 64");

  property p_mode1_first;
    @(posedge core_clk) disable iff (!nrst)
      (scheme == SCH_MODE1 && !blankFirst) |=>
        (transferClk[0] == $past(lvl[0]) && transferClk[1] == !$past(lvl[0]));
  endproperty
  a_mode1_first: assert property (p_mode1_first) else $error("first clock wrong");

  property p_mode3_fifth;
    @(posedge core_clk) disable iff (!nrst)
      (scheme == SCH_MODE3 && !blankSecond) |=> (transferClk[4] == $past(lvl[1]));
  endproperty
  a_mode3_fifth: assert property (p_mode3_fifth) else $error("fifth clock wrong");

  property p_no_retime;
    @(posedge core_clk) disable iff (!nrst)
      (!blankCtl_q[0] && !blankCtl_q[20]) |-> (blankFirst == hblankIn);
  endproperty
  a_no_retime: assert property (p_no_retime) else $error("blanking retimed");

  property p_retime_one;
    @(posedge core_clk) disable iff (!nrst)
      (blankCtl_q[0] && !blankCtl_q[20]) |-> (blankFirst == $past(hblankIn));
  endproperty
  a_retime_one: assert property (p_retime_one) else $error("one-stage retime wrong");

  property p_retime_two;
    @(posedge core_clk) disable iff (!nrst)
      (blankCtl_q[0] && blankCtl_q[20]) |-> (blankFirst == $past(hblankIn, 2));
  endproperty
  a_retime_two: assert property (p_retime_two) else $error("extra retime wrong");

  property p_retime_second;
    @(posedge core_clk) disable iff (!nrst)
      (blankCtl_q[BLK_RESYNC_LSB + GRP_SECOND] && !blankCtl_q[BLK_EXTRA_LSB + GRP_SECOND]) |->
        (blankSecond == $past(hblankIn));
  endproperty
  a_retime_second: assert property (p_retime_second) else $error("second retime wrong");

  property p_retime_last;
    @(posedge core_clk) disable iff (!nrst)
      (blankCtl_q[BLK_RESYNC_LSB + GRP_LAST] && !blankCtl_q[BLK_EXTRA_LSB + GRP_LAST]) |->
        (blankLast == (blankCtl_q[BLK_LAST_EN] && $past(hblankIn)));
  endproperty
  a_retime_last: assert property (p_retime_last) else $error("last retime wrong");

  property p_last_blank_off;
    @(posedge core_clk) disable iff (!nrst)
      !blankCtl_q[BLK_LAST_EN] |=> (lastStageClk == $past(lvl[2]));
  endproperty
  a_last_blank_off: assert property (p_last_blank_off) else $error("last clock blanked");

  property p_narrow_blank;
    @(posedge core_clk) disable iff (!nrst)
      (scheme == SCH_MODE1 && blankFirst && !wideOn) |=> (transferClk[0] == 1'b0);
  endproperty
  a_narrow_blank: assert property (p_narrow_blank) else $error("blank not low");

  property p_drive_off;
    @(posedge core_clk) disable iff (!nrst)
      (driveCtl_q[DRV_LAST_LSB +: DRV_W] == 3'h0) |=> !driveEn[NUM_DRV-1];
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("driver on at code zero");

  property p_bad_scheme;
    @(posedge core_clk) disable iff (!nrst)
      (scheme == SCH_BAD) |=> (transferClk == 8'h00);
  endproperty
  a_bad_scheme: assert property (p_bad_scheme) else $error("clocks run on bad code");
endmodule : hct_timing_core

// ===== tb/hct_sensor_model.sv
`timescale 1ns/1ns
// Sensor side of the horizontal clock pins: what the CCD inputs really see
module hct_sensor_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] transferClk,
  input wire logic lastStageClk,
  input wire logic resetGateClk,
  input wire logic [4:0] driveEn,
  output logic [9:0] sensed
);
  logic floatLvl_q;
  logic [9:0] pins;
  logic [9:0] enables;
  // A line with its driver off floats; flipping it every cycle stops it passing for a level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      floatLvl_q <= 1'b0;
    end else begin
      floatLvl_q <= ~floatLvl_q;
    end
  end
  // Only the first four clocks and the last stage have enables
  assign pins = {resetGateClk, lastStageClk, transferClk};
  assign enables = {1'b1, driveEn[4], 4'hF, driveEn[3:0]};
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      sensed[i] = enables[i] ? pins[i] : floatLvl_q;
    end
  end
endmodule : hct_sensor_model

// ===== tb/hct_timing_core_tb.sv
`timescale 1ns/1ns
// Self-checking bench for the horizontal clock timing core
module hct_timing_core_tb;
  import hct_pkg::*;
  logic core_clk;
  logic nrst;
  hct_reg_req_s req;
  logic [DATA_W-1:0] rdata;
  logic hblankIn;
  logic [7:0] transferClk;
  logic lastStageClk;
  logic resetGateClk;
  logic [NUM_DRV-1:0] driveEn;
  logic [9:0] sensed;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  hct_timing_core dut (.core_clk(core_clk), .nrst(nrst), .regReq(req), .regRdata(rdata),
    .hblankIn(hblankIn), .transferClk(transferClk), .lastStageClk(lastStageClk),
    .resetGateClk(resetGateClk), .driveEn(driveEn));
  hct_sensor_model sensor (.core_clk(core_clk), .nrst(nrst), .transferClk(transferClk),
    .lastStageClk(lastStageClk), .resetGateClk(resetGateClk), .driveEn(driveEn),
    .sensed(sensed));

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [27:0] exp, input logic [27:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [27:0] d);
    @(posedge core_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [27:0] d);
    @(posedge core_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // Test bit 16 always set by software
  task automatic wr_edge(input logic [7:0] a, input logic [5:0] rise, input logic [5:0] fall);
    wr_reg(a, {12'h001, 2'b00, fall, 2'b00, rise});
  endtask : wr_edge

  // High time of one sensed line in core cycles; 0 if it never rises
  task automatic expect_width(input string what, input int idx, input int exp);
    int n;
    int w;
    n = 0;
    w = 0;
    // A fresh setting needs two edges to reach the pin; sampling earlier sees a stale level
    repeat (2) @(posedge core_clk);
    #1;
    while (sensed[idx] !== 1'b0 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (sensed[idx] !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (sensed[idx] === 1'b1 && w < 200) begin
      @(posedge core_clk);
      #1;
      w++;
    end
    check(what, 28'(exp), 28'(w));
  endtask : expect_width

  task automatic set_scheme(input logic [4:0] code);
    wr_reg(OFS_SCHEME, {23'h0, code});
  endtask : set_scheme

  task automatic test_reset();
    logic [27:0] d;
    logic [7:0] ofs [8] = '{OFS_FIRST, OFS_SECOND, OFS_LAST, OFS_PHASE1, OFS_RGATE, OFS_BLANK,
      OFS_DRIVE, OFS_SCHEME};
    logic [27:0] val [8] = '{28'h0012000, 28'h0012000, 28'h0012000, 28'h0012000, 28'h0011000,
      28'h0000000, 28'h0011111, 28'h0000001};
    for (int i = 0; i < 8; i++) begin
      rd_reg(ofs[i], d);
      check("reset value", val[i], d);
    end
    wr_reg(8'h50, 28'hFFFFFFF);
    rd_reg(8'h50, d);
    check("unmapped read", 28'h0, d);
    check("drivers after reset", 28'h1F, 28'(driveEn));
    $display("test reset done");
  endtask : test_reset

  task automatic test_edges();
    expect_width("reset gate default", 9, 16);
    wr_edge(OFS_LAST, 6'h05, 6'h25);
    expect_width("last stage wide", 8, 32);
    wr_edge(OFS_LAST, 6'h05, 6'h0D);
    expect_width("last stage narrow", 8, 8);
    wr_edge(OFS_RGATE, 6'h30, 6'h04);
    expect_width("reset gate wrap", 9, 20);
    $display("test edges done");
  endtask : test_edges

  // First reg 16 high, second 8 high, phase-one 24 high
  task automatic test_modes();
    logic [27:0] d;
    wr_edge(OFS_FIRST, 6'h00, 6'h10);
    wr_edge(OFS_SECOND, 6'h08, 6'h10);
    wr_edge(OFS_PHASE1, 6'h00, 6'h18);
    set_scheme(CODE_MODE1);
    expect_width("mode1 first", 0, 16);
    expect_width("mode1 second", 1, 48);
    set_scheme(CODE_MODE2);
    expect_width("mode2 first", 0, 16);
    expect_width("mode2 second", 1, 8);
    set_scheme(CODE_MODE3);
    expect_width("mode3 fifth", 4, 8);
    expect_width("mode3 first", 0, 16);
    set_scheme(CODE_3PH);
    expect_width("phase one", 0, 24);
    expect_width("phase two", 4, 8);
    expect_width("phase three", 6, 16);
    set_scheme(5'h03);
    expect_width("invalid scheme", 0, 0);
    rd_reg(OFS_STATUS, d);
    check("scheme invalid flag", 28'h1, 28'(d[7]));
    set_scheme(CODE_MODE1);
    rd_reg(OFS_STATUS, d);
    check("scheme valid flag", 28'h0, 28'(d[7]));
    $display("test modes done");
  endtask : test_modes

  // Three back-to-back status reads from the edge blanking rises
  task automatic test_blank_delay();
    logic [27:0] cfg [4] = '{28'h0000000, 28'h0000001, 28'h0100000, 28'h0100001};
    logic [2:0] exp [4] = '{3'b111, 3'b110, 3'b110, 3'b100};
    logic [2:0] b;
    for (int i = 0; i < 4; i++) begin
      wr_reg(OFS_BLANK, cfg[i]);
      repeat (2) @(posedge core_clk);
      hblankIn <= 1'b1;
      req.addr <= OFS_STATUS;
      req.rd <= 1'b1;
      @(posedge core_clk);
      #1;
      b[0] = rdata[8];
      @(posedge core_clk);
      #1;
      b[1] = rdata[8];
      @(posedge core_clk);
      req.rd <= 1'b0;
      #1;
      b[2] = rdata[8];
      check("blanking tap", 28'(exp[i]), 28'(b));
      @(posedge core_clk);
      hblankIn <= 1'b0;
    end
    $display("test blank delay done");
  endtask : test_blank_delay

  task automatic test_wide();
    wr_reg(OFS_BLANK, 28'h0000000);
    hblankIn <= 1'b1;
    expect_width("blanked first", 0, 0);
    wr_reg(OFS_BLANK, 28'h0000010);
    expect_width("wide first", 0, 64);
    wr_reg(OFS_BLANK, 28'h0000000);
    expect_width("last stage unblanked", 8, 8);
    wr_reg(OFS_BLANK, 28'h0000200);
    expect_width("last stage blanked", 8, 0);
    wr_reg(OFS_BLANK, 28'h0000206);
    expect_width("retimed last blanked", 8, 0);
    @(posedge core_clk);
    hblankIn <= 1'b0;
    $display("test wide done");
  endtask : test_wide

  task automatic test_drive();
    logic [27:0] d;
    wr_reg(OFS_DRIVE, 28'h0000010);
    @(posedge core_clk);
    #1;
    check("drivers second only", 28'h02, 28'(driveEn));
    expect_width("first floating", 0, 1);
    expect_width("second driven", 1, 48);
    wr_reg(OFS_DRIVE, 28'h0070000);
    @(posedge core_clk);
    #1;
    check("drivers last only", 28'h10, 28'(driveEn));
    rd_reg(OFS_DRIVE, d);
    check("drive readback", 28'h0070000, d);
    $display("test drive done");
  endtask : test_drive

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard well beyond the expected run length
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      $display("ERROR timeout expected %0d seen %0d", 0, cycles);
      wrap_up();
    end
  end

  initial begin
    nrst = 1'b0;
    req = '0;
    hblankIn = 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    test_reset();
    test_edges();
    test_modes();
    test_blank_delay();
    test_wide();
    test_drive();
    wrap_up();
  end
endmodule : hct_timing_core_tb
